/* File: pxb_pkg.sv */
/*
 Package of the expansion bus and address decode block: map bounds,
 window bases, pin-function bits and timing counts.
 Assumes a 125 MHz system clock.
*/
package pxb_pkg;
	localparam int CLK_MHZ = 125;
	localparam logic [19:0] SRAM_TOP = 20'h7ffff;
	localparam logic [19:0] AUX_BASE = 20'h80000;
	localparam logic [19:0] BOOT_BASE = 20'hc0000;
	localparam logic [7:0] WIN_SEL0 = 8'h08;
	localparam logic [7:0] WIN_SEL1 = 8'h09;
	localparam logic [7:0] WIN_SEL3 = 8'h0b;
	localparam logic [7:0] WIN_RTC = 8'h0d;
	localparam logic [7:0] WIN_ADC = 8'h0e;
	localparam logic [7:0] WIN_CTL = 8'hff;
	localparam int SEL0_BIT = 0;
	localparam int SEL1_BIT = 1;
	localparam logic [1:0] MODE_RESET = 2'h3;
	localparam logic [1:0] DIR_RESET = 2'h3;
	localparam int FLASH_WRITE_US = 5000;
	localparam int FLASH_WRITE_CYC = FLASH_WRITE_US * CLK_MHZ;
	typedef enum logic [1:0] {
		PXB_MEM_SRAM,
		PXB_MEM_AUX,
		PXB_MEM_BOOT
	} pxb_mem_t;
	typedef enum logic [2:0] {
		PXB_IO_NONE,
		PXB_IO_SEL0,
		PXB_IO_SEL1,
		PXB_IO_SEL3,
		PXB_IO_RTC,
		PXB_IO_ADC,
		PXB_IO_CTL
	} pxb_io_t;
endpackage : pxb_pkg

/* File: pxb_irq_in.sv */
/*
 One external interrupt input: three-stage synchroniser, rising-edge or
 level detection, gated by configuration and mask.
 Assumes the input pin is asynchronous to clk_sys_in.
*/
`timescale 1ns/1ps
module pxb_irq_in (
	input wire logic clk_sys_in, // System clock
	input wire logic arst_n_in, // Async reset, active low
	input wire logic clk_en_in, // Clock enable
	input wire logic pin_in, // Raw interrupt pin
	input wire logic configured_in, // Mode programmed
	input wire logic level_mode_in, // 1 level, 0 edge
	input wire logic mask_in, // 1 masks the input
	input wire logic ack_in, // Clears latched edge request
	output logic req_out // Request to processor
);
	logic [2:0] sync;
	logic stable;
	logic edge_req;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync <= 3'h0;
		end else if (clk_en_in) begin
			sync <= {sync[1:0], pin_in};
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stable <= 1'b0;
		end else if (clk_en_in && (sync[1] == sync[2])) begin
			stable <= sync[2];
		end
	end

	// One request per rising edge; a new edge wins over the acknowledge
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			edge_req <= 1'b0;
		end else if (clk_en_in) begin
			if (sync[1] && sync[2] && !stable) begin
				edge_req <= 1'b1;
			end else if (ack_in || level_mode_in) begin
				edge_req <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			req_out <= 1'b0;
		end else if (clk_en_in) begin
			req_out <= configured_in && !mask_in &&
				(level_mode_in ? stable : edge_req);
		end
	end
endmodule : pxb_irq_in

/* File: pxb_bus.sv */
/*
 Expansion bus and address decode of the embedded computer module:
 memory and I/O decode, multiplexed address/data cycle, shared select
 pins, flash write lockout, external interrupt inputs, DMA gating.
 Assumes a processor-side request port on the same clock; pins that
 come from outside are synchronised inside, except muxed_addr_data_in, which is sampled directly.
*/
`timescale 1ns/1ps
module pxb_bus #(
	parameter int WRITE_CYC = pxb_pkg::FLASH_WRITE_CYC // Flash write time
) (
	input wire logic clk_sys_in, // System clock
	input wire logic arst_n_in, // Async reset, active low
	input wire logic clk_en_in, // Clock enable
	input wire logic req_valid_in, // Processor access request
	output logic req_ready_out, // Request accepted
	input wire logic req_io_in, // 1 I/O space, 0 memory
	input wire logic req_write_in, // 1 write, 0 read
	input wire logic [19:0] req_addr_in, // Access address
	input wire logic [7:0] req_wdata_in, // Write data
	output logic [7:0] rdata_out, // Read data from expansion
	output logic rdata_valid_out, // Read data valid pulse
	output pxb_pkg::pxb_mem_t mem_region_out, // Memory decode
	output pxb_pkg::pxb_io_t io_region_out, // I/O decode
	output logic access_err_out, // Boot read refused pulse
	input wire logic [1:0] port_mode_reg_in, // Mode bits of shared pins
	input wire logic [1:0] port_direction_reg_in, // Direction bits
	input wire logic [1:0] gpio_out_in, // GPIO value for shared pins
	output logic [1:0] gpio_in_out, // Synchronised shared pin level
	output logic [7:0] muxed_addr_data_out, // Bus data/address out
	output logic muxed_addr_data_oe_out, // High while driving
	input wire logic [7:0] muxed_addr_data_in, // Bus data in
	output logic addr_latch_en_out, // Address latch enable
	output logic read_n_out, // Read strobe, active low
	output logic write_n_out, // Write strobe, active low
	output logic [2:0] low_addr_out, // Low address lines
	output logic expansion_select_zero_n_out, // Select zero pin
	output logic expansion_select_one_n_out, // Select one pin
	output logic [1:0] select_pin_oe_out, // Shared pin drive enables
	output logic board_select_three_n_out, // On-board select three
	output logic expansion_reset_n_out, // Reset to expansion
	input wire logic ext_irq_zero_in, // Interrupt pin zero
	input wire logic ext_irq_one_in, // Interrupt pin one
	input wire logic [1:0] irq_configured_in, // Mode programmed
	input wire logic [1:0] irq_level_mode_in, // 1 level, 0 edge
	input wire logic [1:0] irq_mask_in, // 1 masks input
	input wire logic [1:0] irq_ack_in, // Acknowledge edge request
	input wire logic cpu_int_en_in, // Processor interrupt enable
	output logic [1:0] irq_req_out, // Requests after lockout
	input wire logic general_line_one_in, // DMA request line one
	input wire logic general_line_two_in, // DMA request line two
	input wire logic [1:0] dma_alt_fn_in, // Lines in alternate function
	output logic [1:0] dma_req_out, // Hardware DMA requests
	output logic flash_busy_out // Flash write in progress
);
	import pxb_pkg::*;

	if (WRITE_CYC < 1) begin : g_bad_write_cyc
		$error("WRITE_CYC must be at least one");
	end

	typedef enum logic [2:0] {
		PXB_IDLE,
		PXB_ADDR,
		PXB_HOLD,
		PXB_STROBE,
		PXB_END
	} pxb_state_t;

	pxb_state_t state;
	logic [31:0] flash_cnt;
	logic cyc_write;
	logic [7:0] cyc_addr;
	logic [7:0] cyc_data;
	logic [1:0] cyc_sel;
	logic [1:0] sel_fn;
	logic [1:0] irq_raw;
	logic [2:0] dma_sync [2];
	logic [2:0] rst_sync;
	pxb_mem_t mem_dec;
	pxb_io_t io_dec;
	logic is_boot;
	logic is_exp;
	logic blocked;
	logic accept;

	// Memory decode
	always_comb begin
		if (req_addr_in <= SRAM_TOP) begin
			mem_dec = PXB_MEM_SRAM;
		end else if (req_addr_in < BOOT_BASE) begin
			mem_dec = PXB_MEM_AUX;
		end else begin
			mem_dec = PXB_MEM_BOOT;
		end
	end

	// I/O decode on the high byte of a 16-bit port address
	always_comb begin
		case (req_addr_in[15:8])
			WIN_SEL0: io_dec = PXB_IO_SEL0;
			WIN_SEL1: io_dec = PXB_IO_SEL1;
			WIN_SEL3: io_dec = PXB_IO_SEL3;
			WIN_RTC: io_dec = PXB_IO_RTC;
			WIN_ADC: io_dec = PXB_IO_ADC;
			WIN_CTL: io_dec = PXB_IO_CTL;
			default: io_dec = PXB_IO_NONE;
		endcase
	end

	// A pin is a select only after both its mode and direction bits clear
	assign sel_fn[SEL0_BIT] = !port_mode_reg_in[SEL0_BIT] &&
		!port_direction_reg_in[SEL0_BIT];
	assign sel_fn[SEL1_BIT] = !port_mode_reg_in[SEL1_BIT] &&
		!port_direction_reg_in[SEL1_BIT];

	assign is_boot = !req_io_in && (mem_dec == PXB_MEM_BOOT);
	assign is_exp = req_io_in && ((io_dec == PXB_IO_SEL0 && sel_fn[0]) ||
		(io_dec == PXB_IO_SEL1 && sel_fn[1]));
	assign blocked = is_boot && flash_busy_out && !req_write_in;
	assign accept = req_valid_in && clk_en_in && !blocked &&
		(state == PXB_IDLE);
	assign req_ready_out = (state == PXB_IDLE) && !blocked;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mem_region_out <= PXB_MEM_SRAM;
			io_region_out <= PXB_IO_NONE;
			access_err_out <= 1'b0;
			board_select_three_n_out <= 1'b1;
		end else if (clk_en_in) begin
			mem_region_out <= mem_dec;
			io_region_out <= req_io_in ? io_dec : PXB_IO_NONE;
			access_err_out <= req_valid_in && blocked;
			board_select_three_n_out <= !(accept && req_io_in &&
				io_dec == PXB_IO_SEL3);
		end
	end

	// Flash write timer; boot reads stall while it runs
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flash_cnt <= 32'h0;
			flash_busy_out <= 1'b0;
		end else if (clk_en_in) begin
			if (accept && is_boot && req_write_in) begin
				flash_cnt <= 32'(WRITE_CYC - 1);
				flash_busy_out <= 1'b1;
			end else if (flash_cnt != 32'h0) begin
				flash_cnt <= flash_cnt - 32'h1;
			end else begin
				flash_busy_out <= 1'b0;
			end
		end
	end

	// Expansion cycle: address phase, hold, strobe, release
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= PXB_IDLE;
			cyc_write <= 1'b0;
			cyc_addr <= 8'h0;
			cyc_data <= 8'h0;
			cyc_sel <= 2'h0;
		end else if (clk_en_in) begin
			case (state)
				PXB_IDLE: begin
					if (accept && is_exp) begin
						cyc_write <= req_write_in;
						cyc_addr <= req_addr_in[7:0];
						cyc_data <= req_wdata_in;
						cyc_sel <= {io_dec == PXB_IO_SEL1,
							io_dec == PXB_IO_SEL0};
						state <= PXB_ADDR;
					end
				end
				PXB_ADDR: state <= PXB_HOLD;
				PXB_HOLD: state <= PXB_STROBE;
				PXB_STROBE: state <= PXB_END;
				PXB_END: state <= PXB_IDLE;
				default: state <= PXB_IDLE;
			endcase
		end
	end

	// Pin drivers, all registered
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			muxed_addr_data_out <= 8'h0;
			muxed_addr_data_oe_out <= 1'b0;
			addr_latch_en_out <= 1'b0;
			read_n_out <= 1'b1;
			write_n_out <= 1'b1;
			low_addr_out <= 3'h0;
		end else if (clk_en_in) begin
			addr_latch_en_out <= (state == PXB_IDLE) && accept && is_exp;
			if (state == PXB_IDLE && accept && is_exp) begin
				muxed_addr_data_out <= req_addr_in[7:0];
				muxed_addr_data_oe_out <= 1'b1;
				low_addr_out <= req_addr_in[2:0];
			end else if (state == PXB_ADDR) begin
				muxed_addr_data_out <= cyc_data;
				muxed_addr_data_oe_out <= cyc_write;
				read_n_out <= cyc_write;
				write_n_out <= !cyc_write;
			end else if (state == PXB_STROBE) begin
				read_n_out <= 1'b1;
				write_n_out <= 1'b1;
			end else if (state == PXB_END) begin
				muxed_addr_data_oe_out <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_out <= 8'h0;
			rdata_valid_out <= 1'b0;
		end else if (clk_en_in) begin
			rdata_valid_out <= (state == PXB_STROBE) && !cyc_write;
			if (state == PXB_STROBE && !cyc_write) begin
				rdata_out <= muxed_addr_data_in;
			end
		end
	end

	// Shared pins: select function or GPIO output, never both
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			expansion_select_zero_n_out <= 1'b1;
			expansion_select_one_n_out <= 1'b1;
			select_pin_oe_out <= 2'h0;
		end else if (clk_en_in) begin
			select_pin_oe_out <= sel_fn | ~port_direction_reg_in;
			expansion_select_zero_n_out <= sel_fn[0] ?
				!(cyc_sel[0] && state != PXB_IDLE) : gpio_out_in[0];
			expansion_select_one_n_out <= sel_fn[1] ?
				!(cyc_sel[1] && state != PXB_IDLE) : gpio_out_in[1];
		end
	end

	// Reset output follows system reset, released synchronously
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_sync <= 3'h0;
		end else begin
			rst_sync <= {rst_sync[1:0], 1'b1};
		end
	end
	assign expansion_reset_n_out = rst_sync[2];

	for (genvar i = 0; i < 2; i++) begin : g_irq
		pxb_irq_in u_irq (
			.clk_sys_in(clk_sys_in),
			.arst_n_in(arst_n_in),
			.clk_en_in(clk_en_in),
			.pin_in(i == 0 ? ext_irq_zero_in : ext_irq_one_in),
			.configured_in(irq_configured_in[i]),
			.level_mode_in(irq_level_mode_in[i]),
			.mask_in(irq_mask_in[i]),
			.ack_in(irq_ack_in[i]),
			.req_out(irq_raw[i])
		);
	end

	// Interrupts held off while the flash is being written
	assign irq_req_out = (cpu_int_en_in && !flash_busy_out) ?
		irq_raw : 2'h0;

	// Hardware DMA only from lines one and two; none from the bus
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dma_sync[0] <= 3'h0;
			dma_sync[1] <= 3'h0;
			dma_req_out <= 2'h0;
			gpio_in_out <= 2'h0;
		end else if (clk_en_in) begin
			dma_sync[0] <= {dma_sync[0][1:0], general_line_one_in};
			dma_sync[1] <= {dma_sync[1][1:0], general_line_two_in};
			for (int i = 0; i < 2; i++) begin
				// Leaving the alternate function drops a request at once
				if (dma_sync[i][1] == dma_sync[i][2]) begin
					dma_req_out[i] <= dma_sync[i][2] && dma_alt_fn_in[i];
				end else if (!dma_alt_fn_in[i]) begin
					dma_req_out[i] <= 1'b0;
				end
			end
			gpio_in_out <= {expansion_select_one_n_out,
				expansion_select_zero_n_out};
		end
	end
endmodule : pxb_bus

/* File: pxb_bus_asserts.sv */
/* Checker of the expansion bus block's ports.
 Assumes it is bound to every pxb_bus instance. */
`timescale 1ns/1ps
module pxb_bus_asserts (
	input wire logic clk_sys_in, // Clock
	input wire logic arst_n_in, // Reset
	input wire logic req_valid_in, // Request
	input wire logic req_ready_out, // Accepted
	input wire logic req_io_in, // I/O space
	input wire logic req_write_in, // Write
	input wire logic [19:0] req_addr_in, // Address
	input wire logic flash_busy_out, // Flash busy
	input wire logic access_err_out, // Refused
	input wire logic addr_latch_en_out, // ALE
	input wire logic read_n_out, // Read strobe
	input wire logic write_n_out, // Write strobe
	input wire logic rdata_valid_out, // Read done
	input wire logic [7:0] muxed_addr_data_out, // Bus out
	input wire logic muxed_addr_data_oe_out, // Bus drive
	input wire logic [2:0] low_addr_out, // Low address
	input wire logic expansion_select_zero_n_out, // Select zero
	input wire logic expansion_select_one_n_out, // Select one
	input wire logic [1:0] port_mode_reg_in, // Pin mode
	input wire logic [1:0] port_direction_reg_in, // Pin direction
	input wire logic [1:0] irq_req_out, // Requests
	input wire logic [1:0] irq_configured_in, // Configured
	input wire logic [1:0] irq_mask_in, // Masks
	input wire logic [1:0] dma_req_out, // DMA requests
	input wire logic [1:0] dma_alt_fn_in // DMA function
);
	import pxb_pkg::*;
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (!arst_n_in);
	a_ale_single: assert property (
		addr_latch_en_out |=> !addr_latch_en_out) else $error("ale too long");
	a_ale_addr: assert property (
		addr_latch_en_out |-> muxed_addr_data_oe_out &&
		muxed_addr_data_out[2:0] == low_addr_out) else $error("address phase");
	a_one_sel: assert property (
		(!read_n_out || !write_n_out) |-> (read_n_out || write_n_out) &&
		(expansion_select_zero_n_out ^ expansion_select_one_n_out))
		else $error("strobe without one select");
	a_rd_walk: assert property (
		addr_latch_en_out ##1 !read_n_out |=> !read_n_out ##1
		read_n_out && rdata_valid_out) else $error("read cycle shape");
	a_wr_walk: assert property (
		addr_latch_en_out ##1 !write_n_out |-> muxed_addr_data_oe_out
		##1 !write_n_out ##1 write_n_out) else $error("write cycle shape");
	a_boot_lock: assert property (
		req_valid_in && !req_io_in && !req_write_in && flash_busy_out &&
		req_addr_in >= BOOT_BASE |-> !req_ready_out ##1 access_err_out)
		else $error("boot read during flash write");
	a_irq_lock: assert property (
		flash_busy_out |-> irq_req_out == 2'h0) else $error("irq in write");
	a_irq_gate: assert property (
		(irq_req_out & ~$past(irq_configured_in & ~irq_mask_in)) == 2'h0)
		else $error("irq while masked");
	a_sel0_func: assert property (
		(!read_n_out || !write_n_out) && !expansion_select_zero_n_out &&
		expansion_select_one_n_out |->
		port_mode_reg_in[0] == 1'b0 && port_direction_reg_in[0] == 1'b0)
		else $error("select zero not in select function");
	a_sel1_func: assert property (
		(!read_n_out || !write_n_out) && !expansion_select_one_n_out &&
		expansion_select_zero_n_out |->
		port_mode_reg_in[1] == 1'b0 && port_direction_reg_in[1] == 1'b0)
		else $error("select one not in select function");
	a_dma_gate: assert property (
		(dma_req_out & ~$past(dma_alt_fn_in)) == 2'h0) else $error("dma gate");
endmodule : pxb_bus_asserts
bind pxb_bus pxb_bus_asserts i_pxb_bus_asserts (.*);

/* File: pxb_ext_dev.sv */
/* Expansion-side register file with address latch.
 Assumes it sees the block's bus pins on the system clock. */
`timescale 1ns/1ps
module pxb_ext_dev (
	input wire logic clk_sys_in, // Clock
	input wire logic [7:0] bus_out_in, // Block drive value
	input wire logic bus_oe_in, // Block drives bus
	input wire logic ale_in, // Address latch enable
	input wire logic read_n_in, // Read strobe
	input wire logic write_n_in, // Write strobe
	input wire logic sel0_n_in, // Select zero
	input wire logic sel1_n_in, // Select one
	output logic [7:0] bus_in_out // Resolved bus level
);
	logic [7:0] store [16];
	logic [7:0] addr;
	logic [7:0] last = 8'h00;
	logic sel;
	assign sel = !sel0_n_in || !sel1_n_in;
	always_ff @(posedge clk_sys_in) begin
		if (ale_in)
			addr <= bus_out_in;
		if (!write_n_in && sel)
			store[{sel1_n_in, addr[2:0]}] <= bus_out_in;
		last <= bus_in_out;
	end
	// Released bus toggles so no stale value reads as valid
	always_comb begin
		if (bus_oe_in)
			bus_in_out = bus_out_in;
		else if (!read_n_in && sel)
			bus_in_out = store[{sel1_n_in, addr[2:0]}];
		else
			bus_in_out = ~last;
	end
endmodule : pxb_ext_dev

/* File: testbench.sv */
/* Self-checking bench of the expansion bus block.
 Assumes the block and the external register model. */
`timescale 1ns/1ps
module testbench;
	import pxb_pkg::*;
	logic clk_sys_in = 1'b0, arst_n_in = 1'b0, clk_en_in = 1'b1;
	logic req_valid_in = 1'b0, req_io_in = 1'b0, req_write_in = 1'b0;
	logic [19:0] req_addr_in = 20'h00000;
	logic [7:0] req_wdata_in = 8'h00, rdata_out, muxed_addr_data_out;
	logic [7:0] muxed_addr_data_in;
	logic req_ready_out, rdata_valid_out, access_err_out, flash_busy_out;
	logic muxed_addr_data_oe_out, addr_latch_en_out, read_n_out, write_n_out;
	logic expansion_select_zero_n_out, expansion_select_one_n_out;
	logic board_select_three_n_out, expansion_reset_n_out;
	pxb_mem_t mem_region_out;
	pxb_io_t io_region_out;
	logic [1:0] port_mode_reg_in = 2'h3, port_direction_reg_in = 2'h3;
	logic [1:0] gpio_out_in = 2'h0, irq_configured_in = 2'h0;
	logic [1:0] irq_level_mode_in = 2'h0, irq_mask_in = 2'h3;
	logic [1:0] irq_ack_in = 2'h0, dma_alt_fn_in = 2'h0, gpio_in_out;
	logic [1:0] select_pin_oe_out, irq_req_out, dma_req_out;
	logic [2:0] low_addr_out;
	logic ext_irq_zero_in = 1'b0, ext_irq_one_in = 1'b0, cpu_int_en_in = 1'b1;
	logic general_line_one_in = 1'b0, general_line_two_in = 1'b0;
	int mismatches = 0, check_count = 0, n = 0;
	logic [27:0] rows [15] = '{28'h0_00000_0, 28'h0_7ffff_0, 28'h0_80000_1,
		28'h0_bffff_1, 28'h0_c0000_2, 28'h0_fffff_2, 28'h1_00800_1,
		28'h1_008ff_1, 28'h1_00900_2, 28'h1_00b00_3, 28'h1_00d00_4,
		28'h1_00e00_5, 28'h1_0ff00_6, 28'h1_00a00_0, 28'h1_00c00_0};
	pxb_bus #(.WRITE_CYC(20)) i_pxb_bus (.*);
	pxb_ext_dev i_pxb_ext_dev (.clk_sys_in(clk_sys_in),
		.bus_out_in(muxed_addr_data_out), .bus_oe_in(muxed_addr_data_oe_out),
		.ale_in(addr_latch_en_out), .read_n_in(read_n_out),
		.write_n_in(write_n_out), .sel0_n_in(expansion_select_zero_n_out),
		.sel1_n_in(expansion_select_one_n_out),
		.bus_in_out(muxed_addr_data_in));
	always #4 clk_sys_in = ~clk_sys_in;
	task automatic chk(input string what, input logic [7:0] exp, got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys_in);
	endtask : tick
	task automatic hang(input int k, lim);
		if (k >= lim) begin
			mismatches++;
			close_out();
		end
	endtask : hang
	task automatic access(input logic io, wr, input logic [19:0] a,
		input logic [7:0] d);
		int k;
		tick(1);
		req_valid_in <= 1'b1;
		req_io_in <= io;
		req_write_in <= wr;
		req_addr_in <= a;
		req_wdata_in <= d;
		k = 0;
		do begin
			tick(1);
			k++;
		end while (req_ready_out !== 1'b1 && k < 50);
		req_valid_in <= 1'b0;
		hang(k, 50);
	endtask : access
	task automatic rd(input logic [19:0] a, input logic [7:0] exp);
		int k;
		access(1'b1, 1'b0, a, 8'h00);
		for (k = 0; rdata_valid_out !== 1'b1 && k < 20; k++)
			tick(1);
		hang(k, 20);
		chk("read data", exp, rdata_out);
	endtask : rd
	initial begin
		tick(10);
		chk("reset out", 8'h0, {7'h0, expansion_reset_n_out});
		arst_n_in <= 1'b1;
		tick(5);
		chk("reset out", 8'h1, {7'h0, expansion_reset_n_out});
		chk("pin drive", 8'h0, {6'h0, select_pin_oe_out});
		$display("reset done");
		foreach (rows[i]) begin
			req_io_in <= rows[i][24];
			req_addr_in <= rows[i][23:4];
			tick(2);
			chk("region", 8'(rows[i][3:0]), rows[i][24] ? 8'(io_region_out) :
				8'(mem_region_out));
		end
		$display("decode done");
		port_mode_reg_in <= 2'h0;
		tick(1);
		port_direction_reg_in <= 2'h0;
		access(1'b1, 1'b1, 20'h00805, 8'ha5);
		access(1'b1, 1'b1, 20'h00905, 8'h3c);
		rd(20'h00805, 8'ha5);
		rd(20'h00905, 8'h3c);
		port_mode_reg_in <= 2'h1;
		access(1'b1, 1'b1, 20'h00801, 8'h77);
		for (int i = 0; i < 8; i++) begin
			tick(1);
			n += int'(addr_latch_en_out);
		end
		chk("ale in gpio mode", 8'h0, 8'(n));
		chk("gpio pin", 8'h0, {7'h0, expansion_select_zero_n_out});
		chk("pin drive", 8'h3, {6'h0, select_pin_oe_out});
		chk("pin level", 8'h2, {6'h0, gpio_in_out});
		port_mode_reg_in <= 2'h0;
		access(1'b1, 1'b0, 20'h00b00, 8'h00);
		tick(1);
		chk("select three", 8'h0, {7'h0, board_select_three_n_out});
		$display("bus done");
		irq_configured_in <= 2'h3;
		irq_mask_in <= 2'h2;
		access(1'b0, 1'b1, 20'hc0000, 8'h11);
		tick(1);
		req_valid_in <= 1'b1;
		req_write_in <= 1'b0;
		ext_irq_zero_in <= 1'b1;
		tick(2);
		chk("boot read ready", 8'h0, {7'h0, req_ready_out});
		chk("access error", 8'h1, {7'h0, access_err_out});
		req_valid_in <= 1'b0;
		tick(8);
		chk("irq in flash write", 8'h0, {6'h0, irq_req_out});
		for (n = 0; flash_busy_out !== 1'b0 && n < 40; n++)
			tick(1);
		hang(n, 40);
		tick(2);
		chk("irq after write", 8'h1, {6'h0, irq_req_out});
		irq_ack_in <= 2'h1;
		tick(1);
		irq_ack_in <= 2'h0;
		tick(3);
		chk("irq held high pin", 8'h0, {6'h0, irq_req_out});
		ext_irq_zero_in <= 1'b0;
		irq_level_mode_in <= 2'h2;
		ext_irq_one_in <= 1'b1;
		tick(8);
		chk("masked level", 8'h0, {6'h0, irq_req_out});
		irq_mask_in <= 2'h0;
		tick(8);
		chk("level request", 8'h2, {6'h0, irq_req_out});
		ext_irq_one_in <= 1'b0;
		tick(8);
		chk("level released", 8'h0, {6'h0, irq_req_out});
		$display("irq done");
		general_line_one_in <= 1'b1;
		general_line_two_in <= 1'b1;
		dma_alt_fn_in <= 2'h1;
		tick(8);
		chk("dma requests", 8'h1, {6'h0, dma_req_out});
		$display("dma done");
		clk_en_in <= 1'b0;
		dma_alt_fn_in <= 2'h3;
		tick(8);
		chk("dma frozen", 8'h1, {6'h0, dma_req_out});
		clk_en_in <= 1'b1;
		tick(8);
		chk("dma released", 8'h3, {6'h0, dma_req_out});
		$display("hold done");
		close_out();
	end
endmodule : testbench
